/* File: lci_consts.vh */
// Constants for the light curtain status indicator
//Contract
//- Sync valid while either sync beam free
//- Scan steps first to last beam once, then wraps to the first
//- Transmitter main lamp: dark, red, green
//- Secondary lamp flashes 10 s if range wired, then channel
//- Receiver red steady off, 1 Hz external
//- Receiver red flashes 10 Hz on internal
//- Outputs on: green, 1 Hz when weak
//- Yellow lit: interlock blocking, field free
//- Yellow dark otherwise
//- States on, off and locked
`ifndef LCI_CONSTS_VH
`define LCI_CONSTS_VH

// System clock rate in Hz
`define LCI_CLK_HZ        50000000
// Flash rates in Hz
`define LCI_SLOW_HZ       1
`define LCI_FAST_HZ       10
// Flash window after reset, in seconds
`define LCI_WINDOW_S      10
// Dwell on each beam, in ns, and its cycle count (rounded up)
`define LCI_BEAM_NS       1000
`define LCI_CLK_NS        20
`define LCI_BEAM_CYC      ((`LCI_BEAM_NS + `LCI_CLK_NS - 1) / `LCI_CLK_NS)

// Beam index width and index of the last beam
`define LCI_BEAM_W        4
`define LCI_LAST_BEAM     4'hF
`define LCI_FIRST_BEAM    4'h0

// Operating states
`define LCI_ST_W          2
`define LCI_ST_OFF        2'h0
`define LCI_ST_ON         2'h1
`define LCI_ST_LOCKED     2'h2

`endif

/* File: lci_status.v */
// Light curtain status indication, scanning and operating state
`timescale 1ns/1ps
`include "lci_consts.vh"

module lci_status #(
	parameter [31:0] SLOW_HALF = `LCI_CLK_HZ / (2 * `LCI_SLOW_HZ),
	parameter [31:0] FAST_HALF = `LCI_CLK_HZ / (2 * `LCI_FAST_HZ),
	parameter [31:0] WINDOW_CYC = `LCI_CLK_HZ * `LCI_WINDOW_S
) (
	// Clock and reset
	input  wire                   CLK_SYS,
	input  wire                   RST_B,
	// Optical and wiring inputs (asynchronous)
	input  wire                   BEAM_RX,
	input  wire                   SYNC_BEAM_A_FREE,
	input  wire                   SYNC_BEAM_B_FREE,
	input  wire                   RANGE_SEL_WIRED,
	input  wire                   CHANNEL_TWO,
	// Status from on-chip logic (same clock)
	input  wire                   TX_DEVICE_ERROR,
	input  wire                   EXT_FAULT,
	input  wire                   INT_FAULT,
	input  wire                   WEAK_SIGNAL,
	input  wire                   RESTART_INTERLOCK_EN,
	input  wire                   RESTART_REQ,
	// Scan
	output reg  [`LCI_BEAM_W-1:0] BEAM_SEL,
	output reg                    SCAN_DONE,
	output reg                    FIELD_FREE,
	output reg                    SYNC_VALID,
	// State
	output reg  [`LCI_ST_W-1:0]   DEV_STATE,
	output reg                    SAFETY_SWITCH_OUTPUT,
	// Lamps
	output reg                    TX_MAIN_RED,
	output reg                    TX_MAIN_GREEN,
	output reg                    TX_SEC_GREEN,
	output reg                    RX_MAIN_RED,
	output reg                    RX_MAIN_GREEN,
	output reg                    RX_YELLOW
);

	// Synchroniser stages for the five pin inputs
	reg  [4:0]             pin_s1_reg;   // First stage, read only by second
	reg  [4:0]             pin_s2_reg;   // Safe to use
	wire                   beam_rx;
	wire                   sync_a;
	wire                   sync_b;
	wire                   range_wired;
	wire                   chan_two;

	// Scan state
	reg  [31:0]            dwell_reg;    // Cycles spent on current beam
	reg                    all_free_reg; // Accumulates over one scan

	// Flash dividers
	reg  [31:0]            slow_cnt_reg;
	reg  [31:0]            fast_cnt_reg;
	reg                    slow_ph_reg;  // About 1 Hz square wave
	reg                    fast_ph_reg;  // About 10 Hz square wave

	// Flash window after reset
	reg  [31:0]            win_cnt_reg;
	reg                    win_act_reg;

	// Operating state and interlock
	reg  [`LCI_ST_W-1:0]   st_next;
	reg                    int_cls_reg;  // Lock-out caused by internal fault
	reg                    blocking_reg; // Interlock holding outputs off
	reg                    blocking_next;

	assign beam_rx     = pin_s2_reg[0];
	assign sync_a      = pin_s2_reg[1];
	assign sync_b      = pin_s2_reg[2];
	assign range_wired = pin_s2_reg[3];
	assign chan_two    = pin_s2_reg[4];

	// Two-stage synchroniser for all pin inputs
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1_reg <= 5'h00;
			pin_s2_reg <= 5'h00;
		end else begin
			pin_s1_reg <= {CHANNEL_TWO, RANGE_SEL_WIRED, SYNC_BEAM_B_FREE,
				SYNC_BEAM_A_FREE, BEAM_RX};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// Beam scan: dwell on each beam, step first to last, then wrap.
	// Field result only changes at scan end, so response time is up to two scans.
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			dwell_reg    <= 32'h00000000;
			BEAM_SEL     <= `LCI_FIRST_BEAM;
			all_free_reg <= 1'b1;
			FIELD_FREE   <= 1'b0;
			SCAN_DONE    <= 1'b0;
			SYNC_VALID   <= 1'b0;
		end else begin
			SCAN_DONE  <= 1'b0;
			// Either coded sync beam suffices
			SYNC_VALID <= sync_a | sync_b;
			if (dwell_reg == `LCI_BEAM_CYC - 1) begin
				// Sample the beam at end of its dwell
				dwell_reg <= 32'h00000000;
				if (BEAM_SEL == `LCI_LAST_BEAM) begin
					// Scan complete: publish and restart
					FIELD_FREE   <= all_free_reg & beam_rx;
					SCAN_DONE    <= 1'b1;
					all_free_reg <= 1'b1;
					BEAM_SEL     <= `LCI_FIRST_BEAM;
				end else begin
					// Next beam in sequence
					all_free_reg <= all_free_reg & beam_rx;
					BEAM_SEL     <= BEAM_SEL + 4'h1;
				end
			end else begin
				dwell_reg <= dwell_reg + 32'h00000001;
			end
		end
	end

	// Flash dividers from the system clock
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			slow_cnt_reg <= 32'h00000000;
			fast_cnt_reg <= 32'h00000000;
			slow_ph_reg  <= 1'b0;
			fast_ph_reg  <= 1'b0;
		end else begin
			if (slow_cnt_reg >= SLOW_HALF - 32'h1) begin
				slow_cnt_reg <= 32'h00000000;
				slow_ph_reg  <= ~slow_ph_reg;
			end else begin
				slow_cnt_reg <= slow_cnt_reg + 32'h00000001;
			end
			if (fast_cnt_reg >= FAST_HALF - 32'h1) begin
				fast_cnt_reg <= 32'h00000000;
				fast_ph_reg  <= ~fast_ph_reg;
			end else begin
				fast_cnt_reg <= fast_cnt_reg + 32'h00000001;
			end
		end
	end

	// Window timer: runs once from reset release, then holds
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			win_cnt_reg <= 32'h00000000;
			win_act_reg <= 1'b1;
		end else if (win_act_reg) begin
			if (win_cnt_reg >= WINDOW_CYC - 32'h1) begin
				win_act_reg <= 1'b0;
			end else begin
				win_cnt_reg <= win_cnt_reg + 32'h00000001;
			end
		end
	end

	// Next operating state and interlock
	always @* begin
		st_next       = DEV_STATE;
		blocking_next = blocking_reg;
		case (DEV_STATE)
			`LCI_ST_OFF: begin
				// Restart request releases interlock only with the field free; disabling the interlock releases it at once
				if (RESTART_REQ && FIELD_FREE) begin
					blocking_next = 1'b0;
				end
				if (!RESTART_INTERLOCK_EN) begin
					blocking_next = 1'b0;
				end
				if (FIELD_FREE && SYNC_VALID && !blocking_next) begin
					st_next = `LCI_ST_ON;
				end
			end
			`LCI_ST_ON: begin
				// Interruption or lost sync drops outputs
				if (!FIELD_FREE || !SYNC_VALID) begin
					st_next       = `LCI_ST_OFF;
					blocking_next = RESTART_INTERLOCK_EN;
				end
			end
			`LCI_ST_LOCKED: begin
				// Lock-out holds until power is removed
				st_next = `LCI_ST_LOCKED;
			end
			default: begin
				st_next = `LCI_ST_LOCKED;
			end
		endcase
		// Any fault forces lock-out from every state
		if (EXT_FAULT || INT_FAULT) begin
			st_next = `LCI_ST_LOCKED;
		end
	end

	// State registers; interlock armed at start-up
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			DEV_STATE            <= `LCI_ST_OFF;
			blocking_reg         <= 1'b1;
			int_cls_reg          <= 1'b0;
			SAFETY_SWITCH_OUTPUT <= 1'b0;
		end else begin
			DEV_STATE            <= st_next;
			blocking_reg         <= blocking_next;
			// Internal class sticks once seen while locking
			if (INT_FAULT) begin
				int_cls_reg <= 1'b1;
			end
			SAFETY_SWITCH_OUTPUT <= (st_next == `LCI_ST_ON);
		end
	end

	// Lamp drivers; dark under reset stands for unpowered
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			TX_MAIN_RED   <= 1'b0;
			TX_MAIN_GREEN <= 1'b0;
			TX_SEC_GREEN  <= 1'b0;
			RX_MAIN_RED   <= 1'b0;
			RX_MAIN_GREEN <= 1'b0;
			RX_YELLOW     <= 1'b0;
		end else begin
			// Transmitter main: red on error, else green
			TX_MAIN_RED   <= TX_DEVICE_ERROR;
			TX_MAIN_GREEN <= ~TX_DEVICE_ERROR;
			// Secondary: flash in window if wired, then channel
			if (win_act_reg && range_wired) begin
				TX_SEC_GREEN <= slow_ph_reg;
			end else begin
				TX_SEC_GREEN <= chan_two;
			end
			// Receiver main: fault class wins over output state
			case (DEV_STATE)
				`LCI_ST_LOCKED: begin
					RX_MAIN_GREEN <= 1'b0;
					if (int_cls_reg) begin
						RX_MAIN_RED <= fast_ph_reg;
					end else begin
						RX_MAIN_RED <= slow_ph_reg;
					end
				end
				`LCI_ST_ON: begin
					RX_MAIN_RED <= 1'b0;
					// Weak signal flashes the green
					RX_MAIN_GREEN <= WEAK_SIGNAL ? slow_ph_reg : 1'b1;
				end
				default: begin
					// Outputs off: steady red
					RX_MAIN_RED   <= 1'b1;
					RX_MAIN_GREEN <= 1'b0;
				end
			endcase
			// Yellow only when release is possible
			RX_YELLOW <= RESTART_INTERLOCK_EN && blocking_reg &&
				FIELD_FREE && (DEV_STATE == `LCI_ST_OFF);
		end
	end

endmodule

/* File: lci_field.sv */
// Optical field model facing the receiver
`timescale 1ns/1ps
module lci_field (
	// Scan position and obstruction
	input  wire [3:0]  BEAM_SEL,
	input  wire [15:0] block_mask,
	// Received beam, high when free
	output wire        BEAM_RX
);
	// One beam per position; a blocked one never arrives
	assign BEAM_RX = !block_mask[BEAM_SEL];
endmodule

/* File: lci_status_assertions.sv */
// Assertion checker for the status indicator ports
`timescale 1ns/1ps
`include "lci_consts.vh"
module lci_status_chk (
	// Clock and reset
	input wire                   CLK_SYS,
	input wire                   RST_B,
	// Status inputs
	input wire                   TX_DEVICE_ERROR,
	input wire                   EXT_FAULT,
	input wire                   INT_FAULT,
	input wire                   WEAK_SIGNAL,
	input wire                   RESTART_INTERLOCK_EN,
	// Scan outputs
	input wire                   SCAN_DONE,
	input wire [`LCI_BEAM_W-1:0] BEAM_SEL,
	input wire                   FIELD_FREE,
	input wire                   SYNC_VALID,
	// State and lamps
	input wire [`LCI_ST_W-1:0]   DEV_STATE,
	input wire                   SAFETY_SWITCH_OUTPUT,
	input wire                   TX_MAIN_RED,
	input wire                   TX_MAIN_GREEN,
	input wire                   RX_MAIN_RED,
	input wire                   RX_MAIN_GREEN,
	input wire                   RX_YELLOW
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	chk_scan_step: assert property ($past(RST_B) && $changed(BEAM_SEL)
		|-> BEAM_SEL == $past(BEAM_SEL) + 4'h1) else $error("beam skipped");
	chk_scan_wrap: assert property (SCAN_DONE |->
		BEAM_SEL == `LCI_FIRST_BEAM && $past(BEAM_SEL) == `LCI_LAST_BEAM)
		else $error("scan end misplaced");
	chk_tx_main: assert property ($past(RST_B) |-> TX_MAIN_RED ==
		$past(TX_DEVICE_ERROR) && TX_MAIN_GREEN != TX_MAIN_RED)
		else $error("tx main lamp wrong");
	chk_sso_state: assert property (SAFETY_SWITCH_OUTPUT ==
		(DEV_STATE == `LCI_ST_ON)) else $error("outputs disagree");
	chk_fault_lock: assert property (EXT_FAULT || INT_FAULT
		|=> DEV_STATE == `LCI_ST_LOCKED [*3]) else $error("no lock");
	chk_on_cause: assert property ($rose(SAFETY_SWITCH_OUTPUT) |->
		$past(FIELD_FREE) && $past(SYNC_VALID)) else $error("bad on");
	chk_yellow_cause: assert property (RX_YELLOW |-> $past(FIELD_FREE) &&
		$past(RESTART_INTERLOCK_EN) && $past(DEV_STATE) == `LCI_ST_OFF)
		else $error("yellow lit wrongly");
	chk_off_red: assert property ($past(RST_B) &&
		$past(DEV_STATE) == `LCI_ST_OFF |-> RX_MAIN_RED && !RX_MAIN_GREEN)
		else $error("off lamp wrong");
	chk_on_green: assert property ($past(RST_B) && !$past(WEAK_SIGNAL) &&
		$past(DEV_STATE) == `LCI_ST_ON |-> RX_MAIN_GREEN && !RX_MAIN_RED)
		else $error("on lamp wrong");
	chk_yellow_off: assert property (!$past(RESTART_INTERLOCK_EN)
		|-> !RX_YELLOW) else $error("yellow lit while disabled");
	chk_lock_dark: assert property ($past(RST_B) &&
		$past(DEV_STATE) == `LCI_ST_LOCKED |-> !RX_MAIN_GREEN)
		else $error("green lit while locked");
endmodule
bind lci_status lci_status_chk u_chk (
	.CLK_SYS              (CLK_SYS),
	.RST_B                (RST_B),
	.TX_DEVICE_ERROR      (TX_DEVICE_ERROR),
	.EXT_FAULT            (EXT_FAULT),
	.INT_FAULT            (INT_FAULT),
	.WEAK_SIGNAL          (WEAK_SIGNAL),
	.RESTART_INTERLOCK_EN (RESTART_INTERLOCK_EN),
	.SCAN_DONE            (SCAN_DONE),
	.BEAM_SEL             (BEAM_SEL),
	.FIELD_FREE           (FIELD_FREE),
	.SYNC_VALID           (SYNC_VALID),
	.DEV_STATE            (DEV_STATE),
	.SAFETY_SWITCH_OUTPUT (SAFETY_SWITCH_OUTPUT),
	.TX_MAIN_RED          (TX_MAIN_RED),
	.TX_MAIN_GREEN        (TX_MAIN_GREEN),
	.RX_MAIN_RED          (RX_MAIN_RED),
	.RX_MAIN_GREEN        (RX_MAIN_GREEN),
	.RX_YELLOW            (RX_YELLOW)
);

/* File: tb.sv */
// Self-checking bench for the status indicator
`timescale 1ns/1ps
`include "lci_consts.vh"
module tb;
	localparam SH = 10, FH = 2, WC = 200; // Shortened counts
	logic CLK_SYS = 0, RST_B = 0, SYNC_BEAM_A_FREE = 1, SYNC_BEAM_B_FREE = 1;
	logic RANGE_SEL_WIRED = 1, CHANNEL_TWO = 1, TX_DEVICE_ERROR = 0;
	logic EXT_FAULT = 0, INT_FAULT = 0, WEAK_SIGNAL = 0, RESTART_REQ = 0;
	logic RESTART_INTERLOCK_EN = 1, SCAN_DONE, FIELD_FREE, SYNC_VALID;
	logic SAFETY_SWITCH_OUTPUT, TX_MAIN_RED, TX_MAIN_GREEN, TX_SEC_GREEN;
	logic RX_MAIN_RED, RX_MAIN_GREEN, RX_YELLOW;
	logic [3:0] BEAM_SEL;
	logic [1:0] DEV_STATE;
	logic [15:0] block_mask = 16'h0000; // Obstructed beams
	wire BEAM_RX;
	wire [2:0] lamps = {TX_SEC_GREEN, RX_MAIN_GREEN, RX_MAIN_RED};
	int fail_count = 0, n_compared = 0, t, v;
	lci_status #(.SLOW_HALF(SH), .FAST_HALF(FH), .WINDOW_CYC(WC)) DUT (
		.CLK_SYS              (CLK_SYS),
		.RST_B                (RST_B),
		.BEAM_RX              (BEAM_RX),
		.SYNC_BEAM_A_FREE     (SYNC_BEAM_A_FREE),
		.SYNC_BEAM_B_FREE     (SYNC_BEAM_B_FREE),
		.RANGE_SEL_WIRED      (RANGE_SEL_WIRED),
		.CHANNEL_TWO          (CHANNEL_TWO),
		.TX_DEVICE_ERROR      (TX_DEVICE_ERROR),
		.EXT_FAULT            (EXT_FAULT),
		.INT_FAULT            (INT_FAULT),
		.WEAK_SIGNAL          (WEAK_SIGNAL),
		.RESTART_INTERLOCK_EN (RESTART_INTERLOCK_EN),
		.RESTART_REQ          (RESTART_REQ),
		.BEAM_SEL             (BEAM_SEL),
		.SCAN_DONE            (SCAN_DONE),
		.FIELD_FREE           (FIELD_FREE),
		.SYNC_VALID           (SYNC_VALID),
		.DEV_STATE            (DEV_STATE),
		.SAFETY_SWITCH_OUTPUT (SAFETY_SWITCH_OUTPUT),
		.TX_MAIN_RED          (TX_MAIN_RED),
		.TX_MAIN_GREEN        (TX_MAIN_GREEN),
		.TX_SEC_GREEN         (TX_SEC_GREEN),
		.RX_MAIN_RED          (RX_MAIN_RED),
		.RX_MAIN_GREEN        (RX_MAIN_GREEN),
		.RX_YELLOW            (RX_YELLOW)
	);
	lci_field u_field (.BEAM_SEL(BEAM_SEL), .block_mask(block_mask),
		.BEAM_RX(BEAM_RX));
	// Free-running 50 MHz clock
	always #10 CLK_SYS = ~CLK_SYS;
	task cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task chk(input logic [7:0] e, input logic [7:0] a);
		n_compared++;
		if (a !== e) begin
			fail_count++;
			$display("[ERR] %0t exp %h got %h", $time, e, a);
		end
	endtask
	// Toggles of one lamp over n cycles
	task tog(input int i, input int n);
		logic p;
		t = 0;
		p = lamps[i];
		repeat (n) begin
			cyc(1);
			if (lamps[i] !== p) t++;
			p = lamps[i];
		end
	endtask
	// Flash count expected from a half period, one of slack for phase
	function logic inrate(int n, int h);
		return t >= n / h - 1 && t <= n / h + 1;
	endfunction
	task rst;
		@(posedge CLK_SYS) RST_B <= 0;
		cyc(5);
		@(posedge CLK_SYS) RST_B <= 1;
	endtask
	// Bounded wait for the next scan end
	task wscan;
		v = 0;
		while (SCAN_DONE !== 1'b1 && v < 900) begin cyc(1); v++; end
		if (v >= 900) begin
			fail_count++;
			$display("[ERR] %0t scan wait %h limit %h", $time, v, 900);
		end
		cyc(3);
	endtask
	task pulse_req;
		@(posedge CLK_SYS) RESTART_REQ <= 1;
		@(posedge CLK_SYS) RESTART_REQ <= 0;
		cyc(3);
	endtask
	task test_done;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#(20 * 30000);
		fail_count++;
		test_done;
	end
	initial begin
		void'($urandom(32'hC766A492));
		rst();
		tog(2, 100);
		chk(1, inrate(100, SH));
		cyc(150);
		chk(1, TX_SEC_GREEN);
		@(posedge CLK_SYS) CHANNEL_TWO <= 0;
		cyc(5);
		chk(0, TX_SEC_GREEN);
		repeat (8) begin
			v = $urandom;
			@(posedge CLK_SYS) TX_DEVICE_ERROR <= v[0];
			cyc(2);
			chk({v[0], !v[0]}, {TX_MAIN_RED, TX_MAIN_GREEN});
		end
		$display("lamp tests done");
		wscan();
		chk(3'b111, {FIELD_FREE, SYNC_VALID, RX_YELLOW});
		pulse_req();
		chk(5'h0A, {DEV_STATE, RX_YELLOW, RX_MAIN_GREEN, RX_MAIN_RED});
		@(posedge CLK_SYS) WEAK_SIGNAL <= 1;
		tog(1, 100);
		chk(1, inrate(100, SH));
		@(posedge CLK_SYS) {WEAK_SIGNAL, SYNC_BEAM_A_FREE} <= 2'b00;
		cyc(6);
		chk(3'b101, {SYNC_VALID, DEV_STATE});
		@(posedge CLK_SYS) SYNC_BEAM_B_FREE <= 0;
		cyc(6);
		chk(3'b000, {SYNC_VALID, DEV_STATE});
		@(posedge CLK_SYS) {SYNC_BEAM_A_FREE, SYNC_BEAM_B_FREE} <= 2'b11;
		cyc(6);
		pulse_req();
		chk(1, SAFETY_SWITCH_OUTPUT);
		@(posedge CLK_SYS) block_mask <= 16'h0001 << ($urandom % 16);
		wscan();
		wscan();
		pulse_req();
		chk(5'h01, {DEV_STATE, RX_YELLOW, RX_MAIN_GREEN, RX_MAIN_RED});
		// Interlock disabled: clear field alone turns outputs on
		@(posedge CLK_SYS) begin
			block_mask <= 16'h0000;
			RESTART_INTERLOCK_EN <= 0;
		end
		wscan();
		wscan();
		chk(5'h0A, {DEV_STATE, RX_YELLOW, RX_MAIN_GREEN, RX_MAIN_RED});
		$display("state tests done");
		for (int i = 0; i < 2; i++) begin
			rst();
			@(posedge CLK_SYS) {EXT_FAULT, INT_FAULT} <= i ? 2'b10 : 2'b01;
			@(posedge CLK_SYS) {EXT_FAULT, INT_FAULT} <= 2'b00;
			cyc(3);
			chk(3'b100, {DEV_STATE, SAFETY_SWITCH_OUTPUT});
			tog(0, 100);
			chk(1, inrate(100, i ? SH : FH));
		end
		$display("fault tests done");
		// Range wiring absent: lamp shows the channel at once
		@(posedge CLK_SYS) {RANGE_SEL_WIRED, CHANNEL_TWO} <= 2'b01;
		rst();
		tog(2, 100);
		chk(8'h01, t[7:0]);
		chk(1, TX_SEC_GREEN);
		$display("range tests done");
		test_done;
	end
endmodule
